// >>> rtl/dtc_params.svh
// Constants for the dual timer control-field block
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
`define DTC_CTL_OFFSET      12'h00C
`define DTC_CTL_RESET       32'h0000_0000
`define DTC_BIT_A_EN        0
`define DTC_BIT_A_FREEZE    1
`define DTC_BIT_A_EDGE_LO   2
`define DTC_BIT_A_EDGE_HI   3
`define DTC_BIT_RTC_EN      4
`define DTC_BIT_A_TRIG_EN   5
`define DTC_BIT_A_PWM_INV   6
`define DTC_BIT_B_EN        8
`define DTC_BIT_B_FREEZE    9
`define DTC_BIT_B_EDGE_LO   10
`define DTC_BIT_B_EDGE_HI   11
`define DTC_CTL_WMASK       32'h0000_0F7F
`define DTC_ADDR_WIDTH      12
`endif

// >>> rtl/dtc_pkg.sv
// Types for the dual timer control-field block
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_EDGE_RISE,
		DTC_EDGE_FALL,
		DTC_EDGE_RSVD,
		DTC_EDGE_BOTH
	} dtc_edge_e;
	typedef struct packed {
		logic      b_freeze;
		logic      b_enable;
		logic      a_pwm_invert;
		logic      a_trig_enable;
		logic      rtc_enable;
		dtc_edge_e a_edge;
		logic      a_freeze;
		logic      a_enable;
	} dtc_ctl_s;
	typedef enum logic [1:0] {
		DTC_APB_IDLE,
		DTC_APB_SETUP,
		DTC_APB_ACCESS
	} dtc_apb_e;
endpackage : dtc_pkg

// >>> rtl/dtc_half_gate.sv
// Run gate and edge detect for one timer half
`timescale 1ns/10ps
module dtc_half_gate
	import dtc_pkg::*;
(
	// Clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// Control
	input  wire logic      enable,
	input  wire logic      freeze,
	input  wire logic      debug_halt,
	input  wire dtc_edge_e edge_sel,
	input  wire logic      capture_in,
	// Results
	output logic           run,
	output logic           capture_event
);
	logic capture_prev_r;
	logic capture_prev_nxt;
	logic run_r;
	logic run_nxt;
	logic event_r;
	logic event_nxt;

	always_comb
	begin
		capture_prev_nxt = capture_in;
		// Freeze only acts while the debugger holds the processor
		run_nxt = enable && !(freeze && debug_halt);
		event_nxt = 1'b0;
		if (enable)
		begin
			case (edge_sel)
				DTC_EDGE_RISE: event_nxt = capture_in && !capture_prev_r;
				DTC_EDGE_FALL: event_nxt = !capture_in && capture_prev_r;
				DTC_EDGE_BOTH: event_nxt = capture_in != capture_prev_r;
				default:       event_nxt = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			capture_prev_r <= 1'b0;
			run_r          <= 1'b0;
			event_r        <= 1'b0;
		end
		else
		begin
			capture_prev_r <= capture_prev_nxt;
			run_r          <= run_nxt;
			event_r        <= event_nxt;
		end
	end

	assign run           = run_r;
	assign capture_event = event_r;
endmodule : dtc_half_gate

// >>> rtl/dtc_timer_control.sv
// Control register and gating for the two timer halves, APB slave
//
// Function
// RULE_01: Freeze bits act only during debugger halt; otherwise ignored.
// RULE_02: Bit 9 set freezes half B while halted; clear keeps counting.
// RULE_03: Bit 8 enables half B counting or capture; zero disables it.
// RULE_04: Software preserves reserved bit 7 and ignores its read value.
// RULE_05: Bit 6 set inverts the half A PWM output.
// RULE_06: Bit 5 gates the half A converter trigger pulse.
// RULE_07: Converter must be enabled and select this timer as trigger.
// RULE_08: Bit 4 allows real-time-clock counting; zero stops it.
// RULE_09: Bits 3:2 pick capture edge: rise, fall, both; 2 reserved.
// RULE_10: Bit 1 set freezes half A while halted; clear keeps counting.
// RULE_11: Bit 0 enables half A counting or capture; zero disables it.
// RULE_12: All control fields read zero after reset.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "dtc_params.svh"
module dtc_timer_control
	import dtc_pkg::*;
#(
	parameter int ADDR_W = `DTC_ADDR_WIDTH
)
(
	// APB
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Timer side
	input  wire logic              debug_halt,
	input  wire logic              a_pwm_raw,
	input  wire logic              a_trigger_raw,
	input  wire logic              a_capture_in,
	input  wire logic              b_capture_in,
	input  wire logic              rtc_tick,
	// Gated controls
	output logic                   a_run,
	output logic                   b_run,
	output logic                   a_capture_event,
	output logic                   b_capture_event,
	output logic                   a_pwm_out,
	output logic                   a_converter_trigger,
	output logic                   rtc_count_tick,
	output dtc_ctl_s               ctl_view
);
	// Refuse an address bus too narrow to reach the control offset
	if (ADDR_W < 4)
	begin : g_addr_w_check
		$error("ADDR_W too small for the control offset");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file
	logic [31:0] ctl_r;
	logic [31:0] ctl_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pready_r;
	logic        pready_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic [31:0] byte_mask;
	logic        hit;
	logic        access;
	dtc_apb_e    phase_r;
	dtc_apb_e    phase_nxt;

	// Bus phase: an access phase is honoured only after its setup cycle
	always_comb
	begin
		phase_nxt = phase_r;
		case (phase_r)
			DTC_APB_IDLE:
			begin
				if (psel && !penable)
					phase_nxt = DTC_APB_SETUP;
			end
			DTC_APB_SETUP:
			begin
				if (!psel)
					phase_nxt = DTC_APB_IDLE;
				else if (penable)
					phase_nxt = DTC_APB_ACCESS;
			end
			DTC_APB_ACCESS:
			begin
				phase_nxt = DTC_APB_IDLE;
			end
			default:
			begin
				phase_nxt = DTC_APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_r <= DTC_APB_IDLE;
		else
			phase_r <= phase_nxt;
	end

	always_comb
	begin
		byte_mask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
		hit         = paddr == `DTC_CTL_OFFSET;
		access      = psel && penable && (phase_r == DTC_APB_SETUP);
		ctl_nxt     = ctl_r;
		prdata_nxt  = 32'h0000_0000;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		if (access)
		begin
			pready_nxt = 1'b1;
			if (hit && pwrite)
			begin
				// Reserved bit 7 and bits above 11 stay zero
				ctl_nxt = (ctl_r & ~(byte_mask & `DTC_CTL_WMASK))
					| (pwdata & byte_mask & `DTC_CTL_WMASK); // RULE_04
			end
			else if (hit)
			begin
				prdata_nxt = ctl_r & `DTC_CTL_WMASK;
			end
			else
			begin
				pslverr_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_r     <= `DTC_CTL_RESET; // RULE_12
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			ctl_r     <= ctl_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	////////////////////////////////////////////////////////////////////////////////
	// Field view
	dtc_ctl_s ctl;

	always_comb
	begin
		ctl.b_freeze      = ctl_r[`DTC_BIT_B_FREEZE];
		ctl.b_enable      = ctl_r[`DTC_BIT_B_EN];
		ctl.a_pwm_invert  = ctl_r[`DTC_BIT_A_PWM_INV];
		ctl.a_trig_enable = ctl_r[`DTC_BIT_A_TRIG_EN];
		ctl.rtc_enable    = ctl_r[`DTC_BIT_RTC_EN];
		ctl.a_edge        = dtc_edge_e'(ctl_r[`DTC_BIT_A_EDGE_HI:`DTC_BIT_A_EDGE_LO]);
		ctl.a_freeze      = ctl_r[`DTC_BIT_A_FREEZE];
		ctl.a_enable      = ctl_r[`DTC_BIT_A_EN];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Half gating
	dtc_half_gate u_half_a
	(
		.pclk          (pclk),
		.presetn       (presetn),
		.enable        (ctl.a_enable),       // RULE_11
		.freeze        (ctl.a_freeze),       // RULE_10 RULE_01
		.debug_halt    (debug_halt),
		.edge_sel      (ctl.a_edge),         // RULE_09
		.capture_in    (a_capture_in),
		.run           (a_run),
		.capture_event (a_capture_event)
	);

	dtc_half_gate u_half_b
	(
		.pclk          (pclk),
		.presetn       (presetn),
		.enable        (ctl.b_enable),       // RULE_03
		.freeze        (ctl.b_freeze),       // RULE_02 RULE_01
		.debug_halt    (debug_halt),
		.edge_sel      (dtc_edge_e'(ctl_r[`DTC_BIT_B_EDGE_HI:`DTC_BIT_B_EDGE_LO])),
		.capture_in    (b_capture_in),
		.run           (b_run),
		.capture_event (b_capture_event)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Output conditioning
	logic pwm_r;
	logic pwm_nxt;
	logic trig_r;
	logic trig_nxt;
	logic rtc_r;
	logic rtc_nxt;
	dtc_ctl_s view_r;

	always_comb
	begin
		pwm_nxt  = a_pwm_raw ^ ctl.a_pwm_invert;             // RULE_05
		trig_nxt = a_trigger_raw && ctl.a_trig_enable;       // RULE_06
		rtc_nxt  = rtc_tick && ctl.rtc_enable;               // RULE_08
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwm_r  <= 1'b0;
			trig_r <= 1'b0;
			rtc_r  <= 1'b0;
			view_r <= '0;
		end
		else
		begin
			pwm_r  <= pwm_nxt;
			trig_r <= trig_nxt;
			rtc_r  <= rtc_nxt;
			view_r <= ctl;
		end
	end

	assign a_pwm_out           = pwm_r;
	assign a_converter_trigger = trig_r;
	assign rtc_count_tick      = rtc_r;
	assign ctl_view            = view_r;
endmodule : dtc_timer_control

// >>> verif/dtc_timer_control_assertions.sv
// Checker for the timer control block
`timescale 1ns/10ps
module dtc_timer_control_chk
	import dtc_pkg::*;
(
	// Clock, reset and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Timer side
	input wire logic        debug_halt,
	input wire logic        a_pwm_raw,
	input wire logic        a_trigger_raw,
	input wire logic        rtc_tick,
	input wire logic        a_run,
	input wire logic        b_run,
	input wire logic        a_capture_event,
	input wire logic        a_pwm_out,
	input wire logic        a_converter_trigger,
	input wire logic        rtc_count_tick,
	input wire dtc_ctl_s    ctl_view
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
chk_pwm_invert: assert property (
	$stable(ctl_view) |-> a_pwm_out == ($past(a_pwm_raw) ^ ctl_view.a_pwm_invert))
	else $error("pwm level wrong");
chk_trig_gate: assert property (
	$stable(ctl_view) |-> a_converter_trigger == ($past(a_trigger_raw) & ctl_view.a_trig_enable))
	else $error("trigger gate wrong");
chk_rtc_gate: assert property (
	$stable(ctl_view) |-> rtc_count_tick == ($past(rtc_tick) & ctl_view.rtc_enable))
	else $error("rtc gate wrong");
chk_a_run_gate: assert property (
	$stable(ctl_view) |-> a_run == (ctl_view.a_enable & !(ctl_view.a_freeze & $past(debug_halt))))
	else $error("half a run wrong");
chk_b_run_gate: assert property (
	$stable(ctl_view) |-> b_run == (ctl_view.b_enable & !(ctl_view.b_freeze & $past(debug_halt))))
	else $error("half b run wrong");
chk_rsvd_edge: assert property (
	$stable(ctl_view) && ctl_view.a_edge == DTC_EDGE_RSVD |-> !a_capture_event)
	else $error("capture on reserved edge code");
chk_ready_once: assert property (psel && penable && !pready |=> pready)
	else $error("pready late");
chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
	else $error("error response wrong");
endmodule : dtc_timer_control_chk
////////////////////////////////////////////////////////////////////////////////
bind dtc_timer_control dtc_timer_control_chk u_chk
(
	.pclk                (pclk),
	.presetn             (presetn),
	.psel                (psel),
	.penable             (penable),
	.prdata              (prdata),
	.pready              (pready),
	.pslverr             (pslverr),
	.debug_halt          (debug_halt),
	.a_pwm_raw           (a_pwm_raw),
	.a_trigger_raw       (a_trigger_raw),
	.rtc_tick            (rtc_tick),
	.a_run               (a_run),
	.b_run               (b_run),
	.a_capture_event     (a_capture_event),
	.a_pwm_out           (a_pwm_out),
	.a_converter_trigger (a_converter_trigger),
	.rtc_count_tick      (rtc_count_tick),
	.ctl_view            (ctl_view)
);

// >>> verif/dtc_timer_control_tb.sv
// Self-checking bench for the timer control block
`timescale 1ns/10ps
`include "dtc_params.svh"
module dtc_timer_control_tb
	import dtc_pkg::*;
;
logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, debug_halt = '0;
logic a_pwm_raw = '0, a_trigger_raw = '0, a_capture_in = '0, b_capture_in = '0, rtc_tick = '0;
logic [11:0] paddr = '0;
logic [31:0] pwdata = '0, prdata, rd, w;
logic [3:0]  pstrb = 4'hF;
logic        pready, pslverr, er, a_run, b_run, a_capture_event, b_capture_event;
logic        a_pwm_out, a_converter_trigger, rtc_count_tick;
dtc_ctl_s    ctl_view;
int          mismatches = 0, samples_checked = 0, na, nb, na0, nb0;
int          ce [4] = '{1, 1, 0, 2};
// Control word, {halt, pwm, trigger, rtc} inputs, {a_run, b_run, pwm, trigger, rtc} outputs
logic [20:0] rows [5] = '{{12'hFFF, 4'hF, 5'h03}, {12'h001, 4'hC, 5'h14},
	{12'h303, 4'h3, 5'h18}, {12'h371, 4'hB, 5'h17}, {12'h240, 4'h0, 5'h04}};
dtc_timer_control u_dut
(
	.pclk                (pclk),
	.presetn             (presetn),
	.psel                (psel),
	.penable             (penable),
	.pwrite              (pwrite),
	.paddr               (paddr),
	.pwdata              (pwdata),
	.pstrb               (pstrb),
	.prdata              (prdata),
	.pready              (pready),
	.pslverr             (pslverr),
	.debug_halt          (debug_halt),
	.a_pwm_raw           (a_pwm_raw),
	.a_trigger_raw       (a_trigger_raw),
	.a_capture_in        (a_capture_in),
	.b_capture_in        (b_capture_in),
	.rtc_tick            (rtc_tick),
	.a_run               (a_run),
	.b_run               (b_run),
	.a_capture_event     (a_capture_event),
	.b_capture_event     (b_capture_event),
	.a_pwm_out           (a_pwm_out),
	.a_converter_trigger (a_converter_trigger),
	.rtc_count_tick      (rtc_count_tick),
	.ctl_view            (ctl_view)
);
always #12.5 pclk = ~pclk;
always @(posedge pclk)
begin
	na += int'(a_capture_event === 1'h1);
	nb += int'(b_capture_event === 1'h1);
end
////////////////////////////////////////////////////////////////////////////////
task automatic finish_test;
	$display("checks %0d mismatches %0d", samples_checked, mismatches);
	if (mismatches == 0 && samples_checked > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask : finish_test
task automatic chk(input logic [31:0] g, input logic [31:0] x);
	samples_checked++;
	if (g !== x)
	begin
		mismatches++;
		$display("ERROR %0t got %h exp %h", $time, g, x);
	end
endtask : chk
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
	int n;
	@(posedge pclk);
	{psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
	@(posedge pclk);
	penable <= 1'h1;
	n = 0;
	do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
	if (pready !== 1'h1)
	begin
		mismatches++;
		$display("ERROR %0t no pready", $time);
		finish_test();
	end
	rd = prdata;
	er = pslverr;
	{psel, penable} <= 2'h0;
endtask : apb
////////////////////////////////////////////////////////////////////////////////
initial
begin
	repeat (4) @(posedge pclk);
	presetn <= 1'h1;
	foreach (rows[i])
	begin
		w = {20'h0, rows[i][20:9]};
		apb(1'h1, `DTC_CTL_OFFSET, w);
		apb(1'h0, `DTC_CTL_OFFSET, 32'h0);
		chk(rd, w & `DTC_CTL_WMASK);
		{debug_halt, a_pwm_raw, a_trigger_raw, rtc_tick} <= rows[i][8:5];
		repeat (3) @(posedge pclk);
		chk({a_run, b_run, a_pwm_out, a_converter_trigger, rtc_count_tick}, rows[i][4:0]);
		chk(ctl_view, {w[9:8], w[6:0]});
		chk(a_converter_trigger, rows[i][1]);
	end
	// Each edge code, both halves, one pulse on the capture inputs
	for (int e = 0; e < 4; e++)
	begin
		apb(1'h1, `DTC_CTL_OFFSET, 32'h101 | (e << 2) | (e << 10));
		na0 = na;
		nb0 = nb;
		{a_capture_in, b_capture_in} <= 2'h3;
		repeat (4) @(posedge pclk);
		{a_capture_in, b_capture_in} <= 2'h0;
		repeat (4) @(posedge pclk);
		chk(na - na0, ce[e]);
		chk(nb - nb0, ce[e]);
	end
	// Unmapped access is refused and leaves the register alone
	apb(1'h1, 12'h010, 32'h0);
	chk(er, 1'h1);
	chk(rd, 32'h0);
	pstrb <= 4'h2;
	apb(1'h1, `DTC_CTL_OFFSET, 32'h0);
	pstrb <= 4'hF;
	apb(1'h0, `DTC_CTL_OFFSET, 32'h0);
	chk(rd, 32'h0000_000D);
	// Second reset clears every field
	presetn <= 1'h0;
	repeat (2) @(posedge pclk);
	chk(ctl_view, 9'h0);
	presetn <= 1'h1;
	apb(1'h0, `DTC_CTL_OFFSET, 32'h0);
	chk(rd, `DTC_CTL_RESET);
	finish_test();
end
endmodule : dtc_timer_control_tb
